// >>> rtl/tm2_timer.sv
// Timer 2 register block with its counter, source muxes and flags
module tm2_timer (
  input wire logic mclk,
  input wire logic reset,
  input wire tm2_pkg::tm2_sfr_req_t sfr_req,
  input wire tm2_pkg::tm2_events_t events,
  input wire logic [tm2_pkg::PIN_COUNT-1:0] pin_in,
  output logic [7:0] sfr_rdata_q,
  output logic irq_q,
  output logic main_ovf_event_q,
  output logic low_ovf_event_q,
  output logic rx_baud_tick_q,
  output logic tx_baud_tick_q,
  output logic clock_out_pin_q,
  output logic clock_out_oe_q,
  output logic [1:0] pin_route_q
);
  logic [tm2_pkg::PIN_COUNT-1:0] meta_q;
  logic [tm2_pkg::PIN_COUNT-1:0] sync_q;
  logic [7:0] ctl_q, mod_q, ext_q, rl_q, rh_q, tl_q, th_q;
  logic [7:0] tl_d, th_d, rd_mux;
  logic low_flag_q, low_ie_q, cap_prev_q, pin_prev_q, clk_tog_q;
  logic [3:0] pre_q;
  logic page0, page1, wr_ctl, wr_mod, wr_ext, wr_aux;
  logic wr_rl, wr_rh, wr_tl, wr_th;
  logic [2:0] mode, hi_src;
  logic [1:0] lo_src;
  logic split, baud, view, tick12, cnt_pin, trig_pin, cap_src;
  logic cap_fall, cap_rise, ext_hit, trig_act, pin_fall;
  logic lo_tick, lo_inc, lo_ovf, hi_tick, hi_inc, hi_ovf, full_ovf;
  logic main_ovf, reload_mode, capture_mode, baud_src, cko_src;

  // Two-stage synchronisers for every pin input
  for (genvar i = 0; i < tm2_pkg::PIN_COUNT; i++) begin : g_sync
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pin_in[i];
        sync_q[i] <= meta_q[i];
      end
    end
  end

  // Page-qualified address decode
  assign page0 = sfr_req.page == tm2_pkg::PAGE_MAIN;
  assign page1 = sfr_req.page == tm2_pkg::PAGE_AUX;
  assign wr_ctl = sfr_req.wr & page0 & (sfr_req.addr == tm2_pkg::ADDR_CONTROL);
  assign wr_mod = sfr_req.wr & page0 & (sfr_req.addr == tm2_pkg::ADDR_MODE);
  assign wr_rl = sfr_req.wr & page0
    & (sfr_req.addr == tm2_pkg::ADDR_RELOAD_LOW);
  assign wr_rh = sfr_req.wr & page0
    & (sfr_req.addr == tm2_pkg::ADDR_RELOAD_HIGH);
  assign wr_tl = sfr_req.wr & page0
    & (sfr_req.addr == tm2_pkg::ADDR_COUNT_LOW);
  assign wr_th = sfr_req.wr & page0
    & (sfr_req.addr == tm2_pkg::ADDR_COUNT_HIGH);
  assign wr_ext = sfr_req.wr & page1
    & (sfr_req.addr == tm2_pkg::ADDR_MODE_EXT);
  assign wr_aux = sfr_req.wr & page1
    & (sfr_req.addr == tm2_pkg::ADDR_AUX_ROUTE);

  // Field views of the stored registers
  assign mode = {ext_q[tm2_pkg::EXT_MODE1], ctl_q[tm2_pkg::CTL_CPRL],
    mod_q[tm2_pkg::MOD_MODE0]};
  assign hi_src = {ext_q[tm2_pkg::EXT_GROUP], mod_q[tm2_pkg::MOD_FAST],
    ctl_q[tm2_pkg::CTL_CNT_SEL]};
  assign lo_src = {ext_q[tm2_pkg::EXT_LOW_GROUP],
    mod_q[tm2_pkg::MOD_LOW_FAST]};
  assign split = mod_q[tm2_pkg::MOD_SPLIT];
  assign baud = ctl_q[tm2_pkg::CTL_RXSEL] | ctl_q[tm2_pkg::CTL_TXSEL];
  assign view = ext_q[tm2_pkg::EXT_VIEW];

  // Pin routing and capture source selection
  always_comb begin
    case (pin_route_q)
      tm2_pkg::ROUTE_P1: begin
        cnt_pin = sync_q[tm2_pkg::PIN_P10];
        trig_pin = sync_q[tm2_pkg::PIN_P11];
      end
      tm2_pkg::ROUTE_P3: begin
        cnt_pin = sync_q[tm2_pkg::PIN_P30];
        trig_pin = sync_q[tm2_pkg::PIN_P31];
      end
      tm2_pkg::ROUTE_P6: begin
        cnt_pin = sync_q[tm2_pkg::PIN_P60];
        trig_pin = sync_q[tm2_pkg::PIN_P35];
      end
      default: begin
        cnt_pin = sync_q[tm2_pkg::PIN_P45];
        trig_pin = sync_q[tm2_pkg::PIN_P44];
      end
    endcase
    case (ext_q[tm2_pkg::EXT_CAP_MSB:0])
      tm2_pkg::CAP_TRIG: cap_src = trig_pin;
      tm2_pkg::CAP_RXD: cap_src = sync_q[tm2_pkg::PIN_RXD];
      tm2_pkg::CAP_P60: cap_src = sync_q[tm2_pkg::PIN_P60];
      tm2_pkg::CAP_INT2: cap_src = events.int2;
      tm2_pkg::CAP_KEYPAD: cap_src = events.keypad;
      tm2_pkg::CAP_SCL: cap_src = sync_q[tm2_pkg::PIN_SCL];
      default: cap_src = 1'b0; // Reserved codes never trigger
    endcase
  end

  // Edge detection; event pulses count as a rise then a fall
  assign cap_fall = cap_prev_q & ~cap_src;
  assign cap_rise = ~cap_prev_q & cap_src;
  assign ext_hit = (cap_fall & ctl_q[tm2_pkg::CTL_FALL_EN])
    | (cap_rise & mod_q[tm2_pkg::MOD_RISE_EN]);
  assign trig_act = ext_hit & ~baud;
  assign pin_fall = pin_prev_q & ~cnt_pin;
  assign tick12 = pre_q == tm2_pkg::PRESCALE_LAST;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cap_prev_q <= 1'b0;
      pin_prev_q <= 1'b0;
      pre_q <= 4'h0;
    end else begin
      cap_prev_q <= cap_src;
      pin_prev_q <= cnt_pin;
      pre_q <= tick12 ? 4'h0 : pre_q + 4'h1;
    end
  end

  // Count enables for both halves
  always_comb begin
    case (lo_src)
      tm2_pkg::LSRC_DIV12: lo_tick = tick12;
      tm2_pkg::LSRC_SYSCLK: lo_tick = 1'b1;
      tm2_pkg::LSRC_SER0_OVF: lo_tick = events.serial0_timer_overflow;
      default: lo_tick = events.int0;
    endcase
    lo_inc = split & mod_q[tm2_pkg::MOD_LOW_RUN] & lo_tick;
    lo_ovf = lo_inc & (tl_q == 8'hFF);
    case (hi_src)
      tm2_pkg::SRC_DIV12: hi_tick = tick12;
      tm2_pkg::SRC_PIN: hi_tick = pin_fall;
      tm2_pkg::SRC_SYSCLK: hi_tick = 1'b1;
      tm2_pkg::SRC_INT0: hi_tick = split ? lo_ovf : events.int0;
      tm2_pkg::SRC_SER0_OVF: hi_tick = events.serial0_timer_overflow;
      tm2_pkg::SRC_TMR0_OVF: hi_tick = events.timer0_overflow;
      tm2_pkg::SRC_KEYPAD: hi_tick = events.keypad;
      default: hi_tick = 1'b0;
    endcase
    hi_inc = ctl_q[tm2_pkg::CTL_RUN] & hi_tick;
    full_ovf = ~split & hi_inc & ({th_q, tl_q} == 16'hFFFF);
    hi_ovf = split & hi_inc & (th_q == 8'hFF);
    main_ovf = full_ovf | hi_ovf;
    reload_mode = baud | (mode == tm2_pkg::MODE_AR)
      | (mode == tm2_pkg::MODE_ARX) | (mode == tm2_pkg::MODE_PWM);
    capture_mode = ~baud & ((mode == tm2_pkg::MODE_CAP)
      | (mode == tm2_pkg::MODE_CAPZ));
    baud_src = split ? lo_ovf : full_ovf;
    cko_src = split ? lo_ovf : main_ovf;
  end

  // Counter next value: count, reload, zero, then software write
  always_comb begin
    tl_d = tl_q;
    th_d = th_q;
    if (split) begin
      if (lo_inc) begin
        tl_d = (lo_ovf && reload_mode) ? rl_q : tl_q + 8'h01;
      end
      if (hi_inc) begin
        th_d = (hi_ovf && reload_mode) ? rh_q : th_q + 8'h01;
      end
      if (hi_ovf && mode == tm2_pkg::MODE_PWM) begin
        tl_d = rl_q; // PWM compare refreshed each period
      end
    end else if (hi_inc) begin
      if (full_ovf && reload_mode) begin
        {th_d, tl_d} = {rh_q, rl_q};
      end else begin
        {th_d, tl_d} = {th_q, tl_q} + 16'h0001;
      end
    end
    if (trig_act && reload_mode) begin
      {th_d, tl_d} = {rh_q, rl_q};
    end
    if (trig_act && mode == tm2_pkg::MODE_CAPZ) begin
      th_d = 8'h00;
      if (!split) begin
        tl_d = 8'h00;
      end
    end
    if (wr_tl) begin
      tl_d = sfr_req.wdata;
    end
    if (wr_th) begin
      th_d = sfr_req.wdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      tl_q <= tm2_pkg::RESET_BYTE;
      th_q <= tm2_pkg::RESET_BYTE;
    end else begin
      tl_q <= tl_d;
      th_q <= th_d;
    end
  end

  // Reload/capture pair; a capture beats a same-cycle write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rl_q <= tm2_pkg::RESET_BYTE;
      rh_q <= tm2_pkg::RESET_BYTE;
    end else if (trig_act && capture_mode) begin
      rl_q <= tl_q;
      rh_q <= th_q;
    end else begin
      if (wr_rl) begin
        rl_q <= sfr_req.wdata;
      end
      if (wr_rh) begin
        rh_q <= sfr_req.wdata;
      end
    end
  end

  // Control register; hardware sets land after the write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctl_q <= tm2_pkg::RESET_BYTE;
    end else begin
      if (wr_ctl) begin
        ctl_q[7:6] <= sfr_req.wdata[7:6];
        ctl_q[3:0] <= sfr_req.wdata[3:0];
        if (!view) begin
          ctl_q[5:4] <= sfr_req.wdata[5:4];
        end
      end
      if (main_ovf && !baud) begin
        ctl_q[tm2_pkg::CTL_OVF] <= 1'b1;
      end
      if (ext_hit) begin
        ctl_q[tm2_pkg::CTL_EXT] <= 1'b1;
      end
    end
  end

  // Low-byte flag and its enable, reached through the view select
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      low_flag_q <= 1'b0;
      low_ie_q <= 1'b0;
    end else begin
      if (wr_ctl && view) begin
        low_flag_q <= sfr_req.wdata[tm2_pkg::CTL_RXSEL];
        low_ie_q <= sfr_req.wdata[tm2_pkg::CTL_TXSEL];
      end
      if (lo_ovf) begin
        low_flag_q <= 1'b1;
      end
    end
  end

  // Mode register; autoclear of low run overrides the write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      mod_q <= tm2_pkg::RESET_BYTE;
    end else begin
      if (wr_mod) begin
        mod_q <= sfr_req.wdata;
      end
      if (mod_q[tm2_pkg::MOD_AUTOCLR] && ((main_ovf && mode[2:1] == 2'h0)
          || (trig_act && mode[2:1] == 2'h1))) begin
        mod_q[tm2_pkg::MOD_LOW_RUN] <= 1'b0;
      end
    end
  end

  // Page 1 registers; only the route bits of the aux register live here
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ext_q <= tm2_pkg::RESET_BYTE;
      pin_route_q <= 2'h0;
    end else begin
      if (wr_ext) begin
        ext_q <= sfr_req.wdata;
      end
      if (wr_aux) begin
        pin_route_q <= sfr_req.wdata[tm2_pkg::AUX_ROUTE_MSB:
          tm2_pkg::AUX_ROUTE_LSB];
      end
    end
  end

  // Read multiplexer; unmapped or wrong-page reads return zero
  always_comb begin
    rd_mux = 8'h00;
    if (page0) begin
      case (sfr_req.addr)
        tm2_pkg::ADDR_CONTROL: begin
          rd_mux = ctl_q;
          if (view) begin
            rd_mux[5:4] = {low_flag_q, low_ie_q};
          end
        end
        tm2_pkg::ADDR_MODE: rd_mux = mod_q;
        tm2_pkg::ADDR_RELOAD_LOW: rd_mux = rl_q;
        tm2_pkg::ADDR_RELOAD_HIGH: rd_mux = rh_q;
        tm2_pkg::ADDR_COUNT_LOW: rd_mux = tl_q;
        tm2_pkg::ADDR_COUNT_HIGH: rd_mux = th_q;
        default: rd_mux = 8'h00;
      endcase
    end else if (page1) begin
      case (sfr_req.addr)
        tm2_pkg::ADDR_MODE_EXT: rd_mux = ext_q;
        tm2_pkg::ADDR_AUX_ROUTE: rd_mux = {pin_route_q, 6'h00};
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Registered outputs toward CPU, serial port and pins
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sfr_rdata_q <= 8'h00;
      irq_q <= 1'b0;
      main_ovf_event_q <= 1'b0;
      low_ovf_event_q <= 1'b0;
      rx_baud_tick_q <= 1'b0;
      tx_baud_tick_q <= 1'b0;
      clk_tog_q <= 1'b0;
      clock_out_pin_q <= 1'b0;
      clock_out_oe_q <= 1'b0;
    end else begin
      if (sfr_req.rd) begin
        sfr_rdata_q <= rd_mux;
      end
      irq_q <= (ctl_q[tm2_pkg::CTL_OVF] & ~ext_q[tm2_pkg::EXT_OVF_IGNORE])
        | ctl_q[tm2_pkg::CTL_EXT] | (low_flag_q & low_ie_q);
      main_ovf_event_q <= main_ovf;
      low_ovf_event_q <= lo_ovf;
      // Serial port picks its own modes 1 and 3; we only steer the tick
      rx_baud_tick_q <= ctl_q[tm2_pkg::CTL_RXSEL] ? baud_src
        : events.t1of;
      tx_baud_tick_q <= ctl_q[tm2_pkg::CTL_TXSEL] ? baud_src
        : events.t1of;
      if (cko_src) begin
        clk_tog_q <= ~clk_tog_q; // Half the overflow rate, 50% duty
      end
      clock_out_oe_q <= mod_q[tm2_pkg::MOD_CLKOUT];
      clock_out_pin_q <= mod_q[tm2_pkg::MOD_CLKOUT]
        & ~ctl_q[tm2_pkg::CTL_CPRL] & clk_tog_q;
    end
  end

  // Checks kept beside the logic
  a_ovf_sets_flag: assert property (@(posedge mclk) disable iff (reset)
    main_ovf && !baud |=> ctl_q[tm2_pkg::CTL_OVF])
    else $error("overflow did not set main flag");
  a_baud_no_flag: assert property (@(posedge mclk) disable iff (reset)
    baud && !wr_ctl |=> $stable(ctl_q[tm2_pkg::CTL_OVF]))
    else $error("main flag changed in baud use");
  a_edge_sets_flag: assert property (@(posedge mclk) disable iff (reset)
    ext_hit |=> ctl_q[tm2_pkg::CTL_EXT] ##1 irq_q)
    else $error("edge did not flag and request interrupt");
  a_rx_baud_route: assert property (@(posedge mclk) disable iff (reset)
    ctl_q[tm2_pkg::CTL_RXSEL] && baud_src && !wr_ctl |=> rx_baud_tick_q)
    else $error("receive tick not routed from this timer");
  a_tx_baud_t1: assert property (@(posedge mclk) disable iff (reset)
    !ctl_q[tm2_pkg::CTL_TXSEL] |=> tx_baud_tick_q == $past(events.t1of))
    else $error("transmit tick not from timer 1");
  a_low_flag_set: assert property (@(posedge mclk) disable iff (reset)
    lo_ovf |=> low_flag_q)
    else $error("low overflow did not set low flag");
  a_low_irq_gate: assert property (@(posedge mclk) disable iff (reset)
    low_flag_q && !low_ie_q && !ctl_q[tm2_pkg::CTL_EXT]
    && (!ctl_q[tm2_pkg::CTL_OVF] || ext_q[tm2_pkg::EXT_OVF_IGNORE])
    |=> !irq_q)
    else $error("masked low flag raised interrupt");
  a_baud_no_capture: assert property (@(posedge mclk) disable iff (reset)
    baud && ext_hit && !wr_rl |=> $stable(rl_q))
    else $error("edge captured while clocking serial port");
  a_run_stopped: assert property (@(posedge mclk) disable iff (reset)
    !ctl_q[tm2_pkg::CTL_RUN] && !split && !trig_act && !wr_tl && !wr_th
    |=> $stable({th_q, tl_q}))
    else $error("stopped timer counted");
  a_autoclear_low: assert property (@(posedge mclk) disable iff (reset)
    mod_q[tm2_pkg::MOD_AUTOCLR] && main_ovf && mode == tm2_pkg::MODE_AR
    |=> !mod_q[tm2_pkg::MOD_LOW_RUN])
    else $error("low run not cleared on high overflow");
  a_clkout_off: assert property (@(posedge mclk) disable iff (reset)
    !mod_q[tm2_pkg::MOD_CLKOUT] |=> !clock_out_pin_q && !clock_out_oe_q)
    else $error("clock output active while disabled");
  a_page_decode: assert property (@(posedge mclk) disable iff (reset)
    sfr_req.wr && !page0 && !trig_act |=> $stable(rl_q))
    else $error("page 0 register written from other page");
  a_set_beats_clear: assert property (@(posedge mclk) disable iff (reset)
    wr_ctl && !sfr_req.wdata[tm2_pkg::CTL_EXT] && ext_hit
    |=> ctl_q[tm2_pkg::CTL_EXT])
    else $error("edge lost against software clear");
endmodule

// >>> shared/tm2_pkg.sv
// Timer 2 register block: addresses, field positions and carrier types
// How it works
// - Overflow sets the main flag unless a baud select is on; software clears it.
// - An enabled falling or rising trigger edge sets the external edge flag.
// - The external edge flag requests the shared timer interrupt.
// - Control bits 5..4 show baud selects or low-byte flag and enable.
// - Receive baud select routes this timer's overflow to the serial receive clock.
// - Transmit baud select routes this timer's overflow to the transmit clock.
// - Split low-byte overflow sets the low-byte flag until software clears it.
// - The low-byte flag interrupts only while its enable bit is set.
// - Enabled falling edge captures or reloads; in baud use it only flags.
// - Enabled rising edge captures or reloads; in baud use it only flags.
// - Main run starts and stops counting; in split mode the high byte only.
// - Three select bits choose the main count source among eight codes.
// - Split enable makes two 8-bit counters instead of one; main source SRC_INT0 clocks the high byte from low overflow.
// - Two low select bits choose the low byte's count source.
// - Low run starts and stops the low byte independently of main run.
// - Autoclear drops low run on high overflow or on capture, by mode.
// - Clock-out enable drives the generated clock onto the clock output pin while the capture/reload mode bit is clear.
// - Three mode bits select reload, capture, auto-zero capture or split PWM.
// - The overflow ignore bit keeps the main flag from interrupting.
// - Three capture source bits choose the trigger input among eight codes.
// - Two route bits map clock and trigger pins to one of four pairs.
// - Main registers decode in page 0; extension and route ones in page 1.
package tm2_pkg;
  // Register addresses and pages
  localparam logic [7:0] ADDR_MODE_EXT = 8'h93;
  localparam logic [7:0] ADDR_AUX_ROUTE = 8'hA4;
  localparam logic [7:0] ADDR_CONTROL = 8'hC8;
  localparam logic [7:0] ADDR_MODE = 8'hC9;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  localparam logic [3:0] PAGE_MAIN = 4'h0;
  localparam logic [3:0] PAGE_AUX = 4'h1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Control register fields
  localparam int CTL_OVF = 7;
  localparam int CTL_EXT = 6;
  localparam int CTL_RXSEL = 5;
  localparam int CTL_TXSEL = 4;
  localparam int CTL_FALL_EN = 3;
  localparam int CTL_RUN = 2;
  localparam int CTL_CNT_SEL = 1;
  localparam int CTL_CPRL = 0;
  // Mode register fields
  localparam int MOD_SPLIT = 7;
  localparam int MOD_LOW_FAST = 6;
  localparam int MOD_RISE_EN = 5;
  localparam int MOD_FAST = 4;
  localparam int MOD_LOW_RUN = 3;
  localparam int MOD_AUTOCLR = 2;
  localparam int MOD_CLKOUT = 1;
  localparam int MOD_MODE0 = 0;
  // Extension mode register fields, then aux route register fields
  localparam int EXT_LOW_GROUP = 7;
  localparam int EXT_OVF_IGNORE = 6;
  localparam int EXT_VIEW = 5;
  localparam int EXT_GROUP = 4;
  localparam int EXT_MODE1 = 3;
  localparam int EXT_CAP_MSB = 2;
  localparam int AUX_ROUTE_MSB = 7;
  localparam int AUX_ROUTE_LSB = 6;
  // Operating modes {mode_bit1, capture_reload_mode, mode_bit0}
  localparam logic [2:0] MODE_AR = 3'h0;
  localparam logic [2:0] MODE_ARX = 3'h1;
  localparam logic [2:0] MODE_CAP = 3'h2;
  localparam logic [2:0] MODE_CAPZ = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h4;
  // Main count sources {clock_group, fast_clock, counter_select}
  localparam logic [2:0] SRC_DIV12 = 3'h0;
  localparam logic [2:0] SRC_PIN = 3'h1;
  localparam logic [2:0] SRC_SYSCLK = 3'h2;
  localparam logic [2:0] SRC_INT0 = 3'h3;
  localparam logic [2:0] SRC_SER0_OVF = 3'h4;
  localparam logic [2:0] SRC_TMR0_OVF = 3'h5;
  localparam logic [2:0] SRC_KEYPAD = 3'h7;
  // Low byte sources {low_clock_group, low_fast_clock}
  localparam logic [1:0] LSRC_DIV12 = 2'h0;
  localparam logic [1:0] LSRC_SYSCLK = 2'h1;
  localparam logic [1:0] LSRC_SER0_OVF = 2'h2;
  localparam logic [1:0] LSRC_INT0 = 2'h3;
  // Capture sources
  localparam logic [2:0] CAP_TRIG = 3'h0;
  localparam logic [2:0] CAP_RXD = 3'h1;
  localparam logic [2:0] CAP_P60 = 3'h2;
  localparam logic [2:0] CAP_INT2 = 3'h3;
  localparam logic [2:0] CAP_KEYPAD = 3'h6;
  localparam logic [2:0] CAP_SCL = 3'h7;
  // Pin routes and pin input indices
  localparam logic [1:0] ROUTE_P1 = 2'h0;
  localparam logic [1:0] ROUTE_P3 = 2'h1;
  localparam logic [1:0] ROUTE_P6 = 2'h2;
  localparam logic [1:0] ROUTE_P4 = 2'h3;
  localparam int PIN_P10 = 0;
  localparam int PIN_P11 = 1;
  localparam int PIN_P30 = 2;
  localparam int PIN_P31 = 3;
  localparam int PIN_P60 = 4;
  localparam int PIN_P35 = 5;
  localparam int PIN_P45 = 6;
  localparam int PIN_P44 = 7;
  localparam int PIN_RXD = 8;
  localparam int PIN_SCL = 9;
  localparam int PIN_COUNT = 10;
  // System clock divided by twelve
  localparam logic [3:0] PRESCALE_LAST = 4'hB;

  typedef struct packed {
    logic [3:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } tm2_sfr_req_t;

  typedef struct packed {
    logic int0;
    logic int2;
    logic keypad;
    logic serial0_timer_overflow;
    logic timer0_overflow;
    logic t1of;
  } tm2_events_t;
endpackage

// >>> tb/tm2_cpu_model.sv
// CPU register bus and serial port stand-in facing the timer block
module tm2_cpu_model (
  input wire logic mclk,
  output tm2_pkg::tm2_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata_q,
  input wire logic rx_baud_tick_q,
  input wire logic tx_baud_tick_q
);
  timeunit 1ns;
  timeprecision 1ps;
  int rx_ticks = 0;
  int tx_ticks = 0;
  initial sfr_req = '0;
  // Serial side only counts the baud ticks it is handed
  always @(posedge mclk) begin
    if (rx_baud_tick_q === 1'b1) rx_ticks++;
    if (tx_baud_tick_q === 1'b1) tx_ticks++;
  end
  // One access held across one rising edge; idle bus shows inverted
  // values so that a stale address or data word can never match
  task automatic xfer(input logic [3:0] pg, input logic [7:0] a,
      input logic w, input logic [7:0] d, output logic [7:0] q);
    tm2_pkg::tm2_sfr_req_t r;
    r = '{page: pg, addr: a, wr: w, rd: ~w, wdata: d};
    @(negedge mclk);
    sfr_req <= r;
    @(negedge mclk);
    q = sfr_rdata_q;
    sfr_req <= '{page: ~pg, addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
endmodule

// >>> tb/timer2_register_control_tb_top.sv
// Self-checking bench for the timer 2 register block
module timer2_register_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
    err_total++; $display("MISMATCH t=%0t got=%0h exp=%0h", $time, g, e); \
    end end
  logic mclk = 1'b0;
  logic reset = 1'b1;
  tm2_pkg::tm2_sfr_req_t sfr_req;
  tm2_pkg::tm2_events_t events = '0;
  logic [tm2_pkg::PIN_COUNT-1:0] pin_in = '1;
  logic [7:0] sfr_rdata_q;
  logic irq_q, main_ovf_event_q, low_ovf_event_q, clock_out_pin_q;
  logic rx_baud_tick_q, tx_baud_tick_q, clock_out_oe_q;
  logic [1:0] pin_route_q;
  logic [7:0] q;
  logic [7:0] d;
  logic [11:0] regs [8] = '{12'h193, 12'h1A4, 12'h0C8, 12'h0C9,
    12'h0CA, 12'h0CB, 12'h0CC, 12'h0CD};
  int err_total = 0;
  int check_count = 0;
  int rx0, tx0;
  // 10 MHz system clock
  always #50 mclk = ~mclk;
  tm2_timer dut (.mclk(mclk), .reset(reset), .sfr_req(sfr_req),
    .events(events), .pin_in(pin_in), .sfr_rdata_q(sfr_rdata_q),
    .irq_q(irq_q), .main_ovf_event_q(main_ovf_event_q),
    .low_ovf_event_q(low_ovf_event_q), .rx_baud_tick_q(rx_baud_tick_q),
    .tx_baud_tick_q(tx_baud_tick_q), .clock_out_pin_q(clock_out_pin_q),
    .clock_out_oe_q(clock_out_oe_q), .pin_route_q(pin_route_q));
  tm2_cpu_model cpu (.mclk(mclk), .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q), .rx_baud_tick_q(rx_baud_tick_q),
    .tx_baud_tick_q(tx_baud_tick_q));
  // Route register keeps only its two top bits
  function automatic logic [7:0] route_view(input logic [7:0] v);
    return {v[7:6], 6'h00};
  endfunction
  task automatic wr(input logic [3:0] pg, input logic [7:0] a,
      input logic [7:0] v);
    logic [7:0] unused;
    cpu.xfer(pg, a, 1'b1, v, unused);
  endtask
  task automatic rd_chk(input logic [3:0] pg, input logic [7:0] a,
      input logic [7:0] e);
    cpu.xfer(pg, a, 1'b0, 8'h00, q);
    `CHK(q, e)
  endtask
  // Stop, preset the count two below rollover, then apply control
  task automatic arm(input logic [7:0] ctl);
    wr(4'h0, 8'hC8, 8'h00);
    wr(4'h0, 8'hCC, 8'hFE);
    wr(4'h0, 8'hCD, 8'hFF);
    wr(4'h0, 8'hC8, ctl);
  endtask
  // Bounded wait on the main or low overflow pulse, one cycle long
  task automatic wait_ovf(input bit lo);
    int k;
    k = 0;
    while ((lo ? low_ovf_event_q : main_ovf_event_q) !== 1'b1
        && k < 20) begin
      @(posedge mclk);
      #1;
      k++;
    end
    `CHK((lo ? low_ovf_event_q : main_ovf_event_q), 1'b1)
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #1000000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(22));
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    reset <= 1'b0;
    // Reset values, then wrong-page writes must be ignored
    foreach (regs[i]) rd_chk(regs[i][11:8], regs[i][7:0], 8'h00);
    wr(4'h1, 8'hC9, 8'hFF);
    rd_chk(4'h0, 8'hC9, 8'h00);
    rd_chk(4'h0, 8'h93, 8'h00);
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      wr(4'h0, 8'hCA + 8'(i % 4), d);
      wr(4'h1, 8'hCA + 8'(i % 4), ~d);
      rd_chk(4'h0, 8'hCA + 8'(i % 4), d);
    end
    d = 8'($urandom);
    wr(4'h1, 8'hA4, d);
    rd_chk(4'h1, 8'hA4, route_view(d));
    `CHK(pin_route_q, d[7:6])
    wr(4'h1, 8'hA4, 8'h00);
    // Plain overflow on the system clock source, then ignore bit
    wr(4'h0, 8'hC9, 8'h12);
    arm(8'h04);
    wait_ovf(1'b0);
    rd_chk(4'h0, 8'hC8, 8'h84);
    `CHK(irq_q, 1'b1)
    // First overflow flips the clock-out level high
    `CHK(clock_out_oe_q, 1'b1)
    `CHK(clock_out_pin_q, 1'b1)
    wr(4'h1, 8'h93, 8'h40);
    repeat (2) @(negedge mclk);
    `CHK(irq_q, 1'b0)
    wr(4'h1, 8'h93, 8'h00);
    // Baud selects: no main flag, ticks reach the serial port
    rx0 = cpu.rx_ticks;
    tx0 = cpu.tx_ticks;
    arm(8'h34);
    wait_ovf(1'b0);
    repeat (2) @(negedge mclk);
    rd_chk(4'h0, 8'hC8, 8'h34);
    `CHK(cpu.rx_ticks, rx0 + 1)
    `CHK(cpu.tx_ticks, tx0 + 1)
    wr(4'h0, 8'hC8, 8'h00);
    // With selects clear the other timer's overflow is passed on
    rx0 = cpu.rx_ticks;
    tx0 = cpu.tx_ticks;
    @(negedge mclk);
    events.t1of <= 1'b1;
    @(negedge mclk);
    events.t1of <= 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(cpu.rx_ticks, rx0 + 1)
    `CHK(cpu.tx_ticks, tx0 + 1)
    // View select swaps bits 5..4 to low flag and its enable
    wr(4'h1, 8'h93, 8'h20);
    wr(4'h0, 8'hC8, 8'h30);
    repeat (2) @(negedge mclk);
    `CHK(irq_q, 1'b1)
    rd_chk(4'h0, 8'hC8, 8'h30);
    wr(4'h1, 8'h93, 8'h00);
    rd_chk(4'h0, 8'hC8, 8'h00);
    wr(4'h1, 8'h93, 8'h20);
    wr(4'h0, 8'hC8, 8'h20);
    repeat (2) @(negedge mclk);
    `CHK(irq_q, 1'b0)
    wr(4'h0, 8'hC8, 8'h00);
    wr(4'h1, 8'h93, 8'h00);
    // Split: low byte runs alone, then a high overflow stops it
    wr(4'h0, 8'hCA, 8'hF0);
    wr(4'h0, 8'hCC, 8'hFE);
    wr(4'h0, 8'hC9, 8'hC8);
    wait_ovf(1'b1);
    wr(4'h1, 8'h93, 8'h20);
    rd_chk(4'h0, 8'hC8, 8'h20);
    wr(4'h0, 8'hC9, 8'hDC);
    wr(4'h0, 8'hCD, 8'hFF);
    wr(4'h0, 8'hC8, 8'h04);
    wait_ovf(1'b0);
    rd_chk(4'h0, 8'hC9, 8'hD4);
    wr(4'h0, 8'hC8, 8'h00);
    wr(4'h1, 8'h93, 8'h00);
    wr(4'h0, 8'hC9, 8'h00);
    // Falling trigger edge in capture mode copies the count
    wr(4'h0, 8'hCC, 8'h5A);
    wr(4'h0, 8'hCD, 8'hA5);
    wr(4'h0, 8'hC8, 8'h09);
    @(negedge mclk);
    pin_in[1] <= 1'b0;
    repeat (6) @(negedge mclk);
    rd_chk(4'h0, 8'hC8, 8'h49);
    rd_chk(4'h0, 8'hCA, 8'h5A);
    rd_chk(4'h0, 8'hCB, 8'hA5);
    `CHK(irq_q, 1'b1)
    tally_and_finish();
  end
endmodule
